// ==== verilog/l2as_pkg.sv ====
/*
 layer 2 address select and filter: shared widths, reset values, kinds and carriers.
 assumes a single clock domain; identities are loaded by mobility management logic.
*/
package l2as_pkg;
   localparam int L2AS_SID_W      = 24;
   localparam int L2AS_LABEL_W    = 10;
   localparam int L2AS_CALLREF_W  = 14;
   localparam int L2AS_CC_W       = 10;
   localparam int L2AS_NC_W       = 14;
   localparam int L2AS_NI_W       = L2AS_CC_W + L2AS_NC_W;
   localparam int L2AS_CELL_W     = 6;
   localparam int L2AS_SEED_W     = 30;
   localparam int L2AS_ENTRIES    = 8;
   localparam int L2AS_IDX_W      = 3;
   localparam logic [23:0] L2AS_BCAST_SID   = 24'hFFFFFF;
   localparam logic [23:0] L2AS_BCAST_NI    = 24'hFFFFFF;
   localparam logic [23:0] L2AS_SID_RST     = 24'h000000;
   localparam logic [9:0]  L2AS_LABEL_RST   = 10'h000;
   localparam logic [29:0] L2AS_SEED_RST    = 30'h00000000;
   localparam logic [1:0]  L2AS_SEED_CC_LSB = 2'h0;

   // kind of short identity carried in an uplink header
   typedef enum logic [2:0] {
      L2AS_KIND_NONE,
      L2AS_KIND_INDIV,
      L2AS_KIND_ALIAS,
      L2AS_KIND_UNEXCH,
      L2AS_KIND_GROUP,
      L2AS_KIND_MGMT,
      L2AS_KIND_LABEL
   } l2as_kind_t;

   // purpose of the uplink transmission
   typedef enum logic [2:0] {
      L2AS_UP_ORIG,
      L2AS_UP_REPLY_INDIV,
      L2AS_UP_REPLY_MGMT,
      L2AS_UP_PRESENCE,
      L2AS_UP_RESERVED,
      L2AS_UP_PACKET
   } l2as_up_t;

   typedef struct packed {
      logic [L2AS_CC_W-1:0] country_code_field;
      logic [L2AS_NC_W-1:0] network_code_field;
   } l2as_network_identity_t;

   // table entry loaded by upper layers
   typedef struct packed {
      logic                    valid;
      l2as_kind_t              kind;
      logic [L2AS_SID_W-1:0]   short_subscriber_id;
      logic                    has_label;
      logic [L2AS_LABEL_W-1:0] label;
   } l2as_entry_t;

   typedef struct packed {
      logic                    valid;
      logic                    scrambled;
      l2as_kind_t              kind;
      logic [L2AS_SID_W-1:0]   short_subscriber_id;
      logic [L2AS_LABEL_W-1:0] label;
   } l2as_uphdr_t;

   typedef struct packed {
      logic                      valid;
      logic                      addressed;
      logic                      is_label;
      logic                      is_callref;
      logic [L2AS_SID_W-1:0]     short_subscriber_id;
      logic [L2AS_LABEL_W-1:0]   label;
      logic [L2AS_CALLREF_W-1:0] call_reference;
   } l2as_dnhdr_t;

   typedef struct packed {
      logic                    valid;
      logic                    accept;
      logic                    broadcast;
      l2as_kind_t              kind;
      logic [L2AS_SID_W-1:0]   dest_short_id;
      logic [L2AS_CALLREF_W-1:0] call_reference;
   } l2as_ind_t;
endpackage

// ==== verilog/l2as_id_table.sv ====
/*
 identity table: small register array of identities and event labels with valid flags.
 assumes one writer port from upper layers and a combinational parallel compare consumer.
*/
`timescale 1ns/10ps
module l2as_id_table #(
   parameter int ENTRIES = l2as_pkg::L2AS_ENTRIES,
   parameter int IDX_W   = l2as_pkg::L2AS_IDX_W
) (
   input  wire logic                   mclk,
   input  wire logic                   reset_n,
   input  wire logic                   wr_en,
   input  wire logic [IDX_W-1:0]       wr_idx,
   input  wire l2as_pkg::l2as_entry_t  wr_entry,
   input  wire logic                   clear_all,
   output l2as_pkg::l2as_entry_t       entries [ENTRIES]
);
   import l2as_pkg::*;

   l2as_entry_t tab_q [ENTRIES];
   l2as_entry_t tab_d [ENTRIES];

   always_comb begin
      for (int i = 0; i < ENTRIES; i++) begin
         tab_d[i] = tab_q[i];
         if (clear_all) begin
            tab_d[i].valid = 1'b0;
         end else if (wr_en && (wr_idx == IDX_W'(i))) begin
            tab_d[i] = wr_entry;
         end
      end
   end

   always_ff @(posedge mclk) begin
      for (int i = 0; i < ENTRIES; i++) begin
         if (!reset_n) begin
            tab_q[i] <= '0;
         end else begin
            tab_q[i] <= tab_d[i];
         end
      end
   end

   assign entries = tab_q;
endmodule

// ==== verilog/l2as_seed_gen.sv ====
/*
 scrambling seed generator: folds network identity and cell number into the seed.
 assumes the cell number and network identity are stable between updates.
*/
`timescale 1ns/10ps
module l2as_seed_gen (
   input  wire logic                             mclk,
   input  wire logic                             reset_n,
   input  wire l2as_pkg::l2as_network_identity_t network_identity,
   input  wire logic [l2as_pkg::L2AS_CELL_W-1:0] cell_number,
   output logic [l2as_pkg::L2AS_SEED_W-1:0]      seed
);
   import l2as_pkg::*;

   logic [L2AS_SEED_W-1:0] seed_q;
   logic [L2AS_SEED_W-1:0] seed_d;

   // only country code, network code and cell number enter the seed
   always_comb begin
      seed_d = {network_identity.country_code_field, network_identity.network_code_field, cell_number};
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         seed_q <= L2AS_SEED_RST;
      end else begin
         seed_q <= seed_d;
      end
   end

   assign seed = seed_q;
endmodule

// ==== verilog/l2as_top.sv ====
/*
 layer 2 address select and filter for the mobile station.
 picks the uplink short identity or label and filters downlink headers.
 assumes headers arrive as one-cycle valid strobes from mac logic on mclk.
*/
// Behaviour
// - event label is ten bits wide
// - call reference label is fourteen bits wide
// - short identities are twenty four bits
// - scramble all except downlink and uplink sync channel
// - seed from cell, country, network code only
// - unreserved uplink carries an individual identity
// - alias over individual, unexchanged as last resort
// - migrating: visitor alias once allocated, else unexchanged
// - reply with identity the base used
// - management call reply uses management identity
// - group identity only for presence indication
// - unexchanged identity copies a home individual identity
// - reserved access sends allocated event label
// - packet pdus carry identity or label
// - packet uplink uses short identity, kind shown
// - accept individual, alias, group, management identities
// - accept unexchanged identity from initial registration
// - unaddressed broadcast pdus are for us
// - all ones short identity always accepted
// - all ones network plus short is domain broadcast
// - labels valid per cell and channel transaction
// - network identity is country then network code
// - labels translated to individual identity upward
`timescale 1ns/10ps
module l2as_top #(
   parameter int ENTRIES = l2as_pkg::L2AS_ENTRIES,
   parameter int IDX_W   = l2as_pkg::L2AS_IDX_W
) (
   input  wire logic                             mclk,
   input  wire logic                             reset_n,
   input  wire logic                             tab_wr_en,
   input  wire logic [IDX_W-1:0]                 tab_wr_idx,
   input  wire l2as_pkg::l2as_entry_t            tab_wr_entry,
   input  wire logic                             tab_clear,
   input  wire logic                             migrating,
   input  wire logic                             home_id_valid,
   input  wire logic [l2as_pkg::L2AS_SID_W-1:0]  home_individual_short_id,
   input  wire l2as_pkg::l2as_network_identity_t network_identity,
   input  wire logic [l2as_pkg::L2AS_CELL_W-1:0] cell_number,
   input  wire logic                             up_req,
   input  wire l2as_pkg::l2as_up_t               up_purpose,
   input  wire logic                             up_sync_channel,
   input  wire logic [l2as_pkg::L2AS_SID_W-1:0]  up_reply_short_id,
   input  wire l2as_pkg::l2as_kind_t             up_reply_kind,
   input  wire logic [l2as_pkg::L2AS_SID_W-1:0]  up_group_short_id,
   input  wire logic                             up_label_valid,
   input  wire logic [l2as_pkg::L2AS_LABEL_W-1:0] up_label,
   input  wire l2as_pkg::l2as_dnhdr_t            dn_hdr,
   input  wire logic                             dn_sync_channel,
   output l2as_pkg::l2as_uphdr_t                 up_hdr,
   output logic                                  up_no_identity,
   output l2as_pkg::l2as_ind_t                   dn_ind,
   output logic                                  dn_scrambled,
   output logic [l2as_pkg::L2AS_SEED_W-1:0]      scramble_seed
);
   import l2as_pkg::*;

   l2as_entry_t entries [ENTRIES];

   l2as_id_table #(
      .ENTRIES (ENTRIES),
      .IDX_W   (IDX_W)
   ) u_table (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .wr_en     (tab_wr_en),
      .wr_idx    (tab_wr_idx),
      .wr_entry  (tab_wr_entry),
      .clear_all (tab_clear),
      .entries   (entries)
   );

   l2as_seed_gen u_seed (
      .mclk             (mclk),
      .reset_n          (reset_n),
      .network_identity (network_identity),
      .cell_number      (cell_number),
      .seed             (scramble_seed)
   );

   // parallel lookup of own identities by kind
   logic                  have_indiv;
   logic                  have_alias;
   logic                  have_mgmt;
   logic [L2AS_SID_W-1:0] indiv_id;
   logic [L2AS_SID_W-1:0] alias_id;
   logic [L2AS_SID_W-1:0] mgmt_id;
   logic [ENTRIES-1:0]    sid_hit;
   logic [ENTRIES-1:0]    lbl_hit;

   genvar g;
   generate
      for (g = 0; g < ENTRIES; g++) begin : g_cmp
         assign sid_hit[g] = entries[g].valid && (entries[g].kind != L2AS_KIND_LABEL)
                             && (entries[g].short_subscriber_id == dn_hdr.short_subscriber_id);
         assign lbl_hit[g] = entries[g].valid && entries[g].has_label
                             && (entries[g].label == dn_hdr.label);
      end
   endgenerate

   // lowest index wins when several entries share a kind
   always_comb begin
      have_indiv = 1'b0;
      have_alias = 1'b0;
      have_mgmt  = 1'b0;
      indiv_id   = L2AS_SID_RST;
      alias_id   = L2AS_SID_RST;
      mgmt_id    = L2AS_SID_RST;
      for (int i = ENTRIES - 1; i >= 0; i--) begin
         if (entries[i].valid && entries[i].kind == L2AS_KIND_INDIV) begin
            have_indiv = 1'b1;
            indiv_id   = entries[i].short_subscriber_id;
         end
         if (entries[i].valid && entries[i].kind == L2AS_KIND_ALIAS) begin
            have_alias = 1'b1;
            alias_id   = entries[i].short_subscriber_id;
         end
         if (entries[i].valid && entries[i].kind == L2AS_KIND_MGMT) begin
            have_mgmt = 1'b1;
            mgmt_id   = entries[i].short_subscriber_id;
         end
      end
   end

   // uplink address selection
   l2as_uphdr_t up_d;
   l2as_uphdr_t up_q;
   logic        noid_d;
   logic        noid_q;

   always_comb begin
      up_d           = '0;
      noid_d         = 1'b0;
      up_d.valid     = up_req;
      up_d.scrambled = up_req;
      up_d.label     = L2AS_LABEL_RST;
      if (up_req) begin
         case (up_purpose)
            L2AS_UP_REPLY_INDIV: begin
               up_d.kind                = up_reply_kind;
               up_d.short_subscriber_id = up_reply_short_id;
            end
            L2AS_UP_REPLY_MGMT: begin
               up_d.kind                = L2AS_KIND_MGMT;
               up_d.short_subscriber_id = mgmt_id;
               noid_d                   = !have_mgmt;
            end
            L2AS_UP_PRESENCE: begin
               up_d.kind                = L2AS_KIND_GROUP;
               up_d.short_subscriber_id = up_group_short_id;
            end
            L2AS_UP_RESERVED: begin
               if (up_label_valid) begin
                  up_d.kind  = L2AS_KIND_LABEL;
                  up_d.label = up_label;
               end else begin
                  up_d.kind                = have_alias ? L2AS_KIND_ALIAS : L2AS_KIND_INDIV;
                  up_d.short_subscriber_id = have_alias ? alias_id : indiv_id;
                  noid_d                   = !(have_alias || have_indiv);
               end
            end
            default: begin
               // originating and packet uplink: short identity only, kind always reported
               if (have_alias) begin
                  up_d.kind                = L2AS_KIND_ALIAS;
                  up_d.short_subscriber_id = alias_id;
               end else if (have_indiv && !migrating) begin
                  up_d.kind                = L2AS_KIND_INDIV;
                  up_d.short_subscriber_id = indiv_id;
               end else if (home_id_valid) begin
                  up_d.kind                = L2AS_KIND_UNEXCH;
                  up_d.short_subscriber_id = home_individual_short_id;
               end else begin
                  up_d.kind = L2AS_KIND_NONE;
                  noid_d    = 1'b1;
               end
            end
         endcase
         if (up_sync_channel) begin
            up_d.scrambled = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         up_q   <= '0;
         noid_q <= 1'b0;
      end else begin
         up_q   <= up_d;
         noid_q <= noid_d;
      end
   end

   assign up_hdr         = up_q;
   assign up_no_identity = noid_q;

   // downlink filter; kinds are not told apart in the header, so any own match accepts
   l2as_ind_t dn_d;
   l2as_ind_t dn_q;
   logic      scr_d;
   logic      scr_q;
   logic      bcast_id;

   assign bcast_id = (dn_hdr.short_subscriber_id == L2AS_BCAST_SID);

   always_comb begin
      dn_d       = '0;
      scr_d      = dn_hdr.valid && !dn_sync_channel;
      dn_d.valid = dn_hdr.valid;
      dn_d.kind  = L2AS_KIND_NONE;
      if (dn_hdr.valid) begin
         if (!dn_hdr.addressed) begin
            dn_d.accept    = 1'b1;
            dn_d.broadcast = 1'b1;
            dn_d.dest_short_id = indiv_id;
         end else if (dn_hdr.is_callref) begin
            dn_d.accept         = 1'b1;
            dn_d.call_reference = dn_hdr.call_reference;
            dn_d.dest_short_id  = have_alias ? alias_id : indiv_id;
         end else if (dn_hdr.is_label) begin
            for (int i = ENTRIES - 1; i >= 0; i--) begin
               if (lbl_hit[i]) begin
                  dn_d.accept        = 1'b1;
                  dn_d.kind          = entries[i].kind;
                  dn_d.dest_short_id = entries[i].short_subscriber_id;
               end
            end
         end else if (bcast_id) begin
            dn_d.accept        = 1'b1;
            dn_d.broadcast     = 1'b1;
            dn_d.kind          = L2AS_KIND_GROUP;
            dn_d.dest_short_id = L2AS_BCAST_SID;
         end else begin
            for (int i = ENTRIES - 1; i >= 0; i--) begin
               if (sid_hit[i]) begin
                  dn_d.accept        = 1'b1;
                  dn_d.kind          = entries[i].kind;
                  dn_d.dest_short_id = dn_hdr.short_subscriber_id;
               end
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         dn_q  <= '0;
         scr_q <= 1'b0;
      end else begin
         dn_q  <= dn_d;
         scr_q <= scr_d;
      end
   end

   assign dn_ind       = dn_q;
   assign dn_scrambled = scr_q;

   // checks
   chk_bcast_accept: assert property (@(posedge mclk) disable iff (!reset_n)
      (dn_hdr.valid && dn_hdr.addressed && !dn_hdr.is_label && !dn_hdr.is_callref && bcast_id)
      |=> (dn_ind.accept && dn_ind.broadcast)) else $error("all ones identity not accepted");
   chk_unaddr_accept: assert property (@(posedge mclk) disable iff (!reset_n)
      (dn_hdr.valid && !dn_hdr.addressed) |=> dn_ind.accept) else $error("unaddressed pdu dropped");
   chk_sync_plain: assert property (@(posedge mclk) disable iff (!reset_n)
      (dn_hdr.valid && dn_sync_channel) |=> !dn_scrambled) else $error("sync channel scrambled");
   chk_up_scramble: assert property (@(posedge mclk) disable iff (!reset_n)
      (up_req && !up_sync_channel) |=> (up_hdr.valid && up_hdr.scrambled)) else $error("uplink not scrambled");
   chk_alias_pref: assert property (@(posedge mclk) disable iff (!reset_n)
      (up_req && up_purpose == L2AS_UP_ORIG && have_alias)
      |=> (up_hdr.kind == L2AS_KIND_ALIAS && up_hdr.short_subscriber_id == $past(alias_id)))
      else $error("alias not preferred");
   chk_unexch_copy: assert property (@(posedge mclk) disable iff (!reset_n)
      (up_hdr.valid && up_hdr.kind == L2AS_KIND_UNEXCH)
      |-> (up_hdr.short_subscriber_id == $past(home_individual_short_id))) else $error("unexchanged not copied");
   chk_reply_same: assert property (@(posedge mclk) disable iff (!reset_n)
      (up_req && up_purpose == L2AS_UP_REPLY_INDIV)
      |=> (up_hdr.short_subscriber_id == $past(up_reply_short_id))) else $error("reply identity differs");
   chk_group_only: assert property (@(posedge mclk) disable iff (!reset_n)
      (up_hdr.valid && up_hdr.kind == L2AS_KIND_GROUP) |-> $past(up_purpose) == L2AS_UP_PRESENCE)
      else $error("group identity outside presence");
   chk_seed_form: assert property (@(posedge mclk) disable iff (!reset_n)
      $stable(network_identity) && $stable(cell_number)
      |=> scramble_seed == {$past(network_identity), $past(cell_number)}) else $error("seed mismatch");
   chk_mgmt_reply: assert property (@(posedge mclk) disable iff (!reset_n)
      (up_req && up_purpose == L2AS_UP_REPLY_MGMT && have_mgmt)
      |=> (up_hdr.kind == L2AS_KIND_MGMT && !up_no_identity))
      else $error("management reply lacks identity");
   chk_label_reserved: assert property (@(posedge mclk) disable iff (!reset_n)
      (up_req && up_purpose == L2AS_UP_RESERVED && up_label_valid)
      |=> (up_hdr.kind == L2AS_KIND_LABEL && up_hdr.label == $past(up_label)))
      else $error("reserved access label lost");
   chk_own_accept: assert property (@(posedge mclk) disable iff (!reset_n)
      (dn_hdr.valid && dn_hdr.addressed && !dn_hdr.is_label && !dn_hdr.is_callref && (|sid_hit))
      |=> (dn_ind.accept && dn_ind.dest_short_id == $past(dn_hdr.short_subscriber_id)))
      else $error("own identity dropped");
   chk_label_xlate: assert property (@(posedge mclk) disable iff (!reset_n)
      (dn_hdr.valid && dn_hdr.addressed && dn_hdr.is_label && !dn_hdr.is_callref && (|lbl_hit))
      |=> (dn_ind.accept && !dn_ind.broadcast))
      else $error("event label not translated");
   chk_dn_answer: assert property (@(posedge mclk) disable iff (!reset_n)
      1'b1 |=> (dn_ind.valid == $past(dn_hdr.valid))) else $error("downlink indication timing");
endmodule

// ==== dv/l2as_bs_model.sv ====
/*
 base station model: sends downlink mac headers to the address filter.
 assumes the bench calls send from one process; one header per call.
*/
`timescale 1ns/10ps
module l2as_base_station_model (
   input  wire logic             mclk,
   output l2as_pkg::l2as_dnhdr_t dn_hdr,
   output logic                  dn_sync_channel
);
   import l2as_pkg::*;
   initial begin
      dn_hdr = '0;
      dn_sync_channel = 1'b0;
   end
   // kinds are never marked in the header, the filter must find them itself
   task automatic send(input logic addr, input logic isl, input logic isc, input logic [23:0] sid,
                       input logic [9:0] lab, input logic [13:0] cref, input logic sync);
      l2as_dnhdr_t h;
      @(negedge mclk);
      dn_hdr = '{1'b1, addr, isl, isc, sid, lab, cref};
      dn_sync_channel = sync;
      @(negedge mclk);
      // released fields show the inverse so stale values cannot match
      h = ~dn_hdr;
      h.valid = 1'b0;
      dn_hdr = h;
      dn_sync_channel = ~sync;
   endtask
endmodule

// ==== dv/l2as_top_tb_top.sv ====
/*
 testbench for the layer 2 address select and filter.
 assumes outputs register one edge after a request taken on rising mclk.
*/
`timescale 1ns/10ps
module l2as_top_tb_top;
   import l2as_pkg::*;
   localparam logic [23:0] A = 24'h123456, S = 24'h2A0B11, G = 24'h0C0FFE;
   localparam logic [23:0] M = 24'h5A5A5A, H = 24'h777001, R = 24'h0BEEF1;
   localparam logic [9:0]  L1 = 10'h155, L2 = 10'h3C1;
   localparam logic [9:0]  CC = 10'h2C5;
   localparam logic [13:0] NC = 14'h1ABC;
   localparam logic [5:0]  CELL = 6'h2D;
   logic                   mclk = 1'b0;
   logic                   reset_n = 1'b0;
   logic                   tab_wr_en = 1'b0;
   logic [2:0]             tab_wr_idx = 3'h0;
   l2as_entry_t            tab_wr_entry = '0;
   logic                   tab_clear = 1'b0;
   logic                   migrating = 1'b0;
   logic                   home_id_valid = 1'b1;
   logic [23:0]            home_individual_short_id = H;
   l2as_network_identity_t network_identity = '{CC, NC};
   logic [5:0]             cell_number = CELL;
   logic                   up_req = 1'b0;
   l2as_up_t               up_purpose = L2AS_UP_ORIG;
   logic                   up_sync_channel = 1'b0;
   logic [23:0]            up_reply_short_id = R;
   l2as_kind_t             up_reply_kind = L2AS_KIND_ALIAS;
   logic [23:0]            up_group_short_id = G;
   logic                   up_label_valid = 1'b1;
   logic [9:0]             up_label = L2;
   l2as_dnhdr_t            dn_hdr;
   logic                   dn_sync_channel;
   l2as_uphdr_t            up_hdr;
   logic                   up_no_identity;
   l2as_ind_t              dn_ind;
   logic                   dn_scrambled;
   logic [29:0]            scramble_seed;
   int                     fails = 0;
   int                     compares = 0;

   always #2.5 mclk = ~mclk;

   l2as_top uut (.mclk(mclk), .reset_n(reset_n), .tab_wr_en(tab_wr_en), .tab_wr_idx(tab_wr_idx),
      .tab_wr_entry(tab_wr_entry), .tab_clear(tab_clear), .migrating(migrating), .home_id_valid(home_id_valid),
      .home_individual_short_id(home_individual_short_id), .network_identity(network_identity),
      .cell_number(cell_number), .up_req(up_req), .up_purpose(up_purpose), .up_sync_channel(up_sync_channel),
      .up_reply_short_id(up_reply_short_id), .up_reply_kind(up_reply_kind), .up_group_short_id(up_group_short_id),
      .up_label_valid(up_label_valid), .up_label(up_label), .dn_hdr(dn_hdr), .dn_sync_channel(dn_sync_channel),
      .up_hdr(up_hdr), .up_no_identity(up_no_identity), .dn_ind(dn_ind), .dn_scrambled(dn_scrambled),
      .scramble_seed(scramble_seed));

   l2as_base_station_model base (.mclk(mclk), .dn_hdr(dn_hdr), .dn_sync_channel(dn_sync_channel));

   task automatic results();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input bit ok, input string msg);
      compares++;
      if (!ok) begin
         fails++;
         $display("MISMATCH t=%0t %s", $time, msg);
      end
   endtask

   task automatic wr(input logic [2:0] idx, input logic v, input l2as_kind_t k, input logic [23:0] sid,
                     input logic [9:0] lab);
      @(negedge mclk);
      tab_wr_en = 1'b1;
      tab_wr_idx = idx;
      tab_wr_entry = '{v, k, sid, lab != 10'h000, lab};
      @(negedge mclk);
      tab_wr_en = 1'b0;
   endtask

   // a label answer carries no short identity worth comparing
   task automatic up(input l2as_up_t p, input logic sync, input l2as_kind_t k, input logic [23:0] sid,
                     input string msg);
      @(negedge mclk);
      up_req = 1'b1;
      up_purpose = p;
      up_sync_channel = sync;
      @(negedge mclk);
      up_req = 1'b0;
      check(up_hdr.valid === 1'b1 && up_hdr.kind === k && up_no_identity === 1'b0 && up_hdr.scrambled === ~sync
            && (k == L2AS_KIND_LABEL || up_hdr.short_subscriber_id === sid), msg);
   endtask

   task automatic dn(input logic addr, input logic isl, input logic [23:0] sid, input logic [9:0] lab,
                     input logic sync, input logic acc, input logic bc, input l2as_kind_t k,
                     input logic [23:0] dest, input string msg);
      base.send(addr, isl, 1'b0, sid, lab, 14'h0000, sync);
      check(dn_ind.valid === 1'b1 && dn_ind.accept === acc && dn_ind.broadcast === bc && dn_scrambled === ~sync
            && (!acc || bc || dn_ind.dest_short_id === dest) && (!acc || !addr || isl || dn_ind.kind === k), msg);
   endtask

   initial begin
      #100000;
      fails++;
      results();
   end

   initial begin
      repeat (6) @(negedge mclk);
      check(up_hdr.valid === 1'b0 && dn_ind.valid === 1'b0, "outputs not idle in reset");
      reset_n = 1'b1;
      @(negedge mclk);
      check(scramble_seed === {CC, NC, CELL}, "seed");
      $display("test reset done");
      wr(3'h0, 1'b1, L2AS_KIND_INDIV, A, L1);
      wr(3'h1, 1'b1, L2AS_KIND_GROUP, G, 10'h000);
      wr(3'h2, 1'b1, L2AS_KIND_MGMT, M, 10'h000);
      up(L2AS_UP_ORIG, 1'b0, L2AS_KIND_INDIV, A, "orig individual");
      wr(3'h3, 1'b1, L2AS_KIND_ALIAS, S, 10'h000);
      up(L2AS_UP_ORIG, 1'b1, L2AS_KIND_ALIAS, S, "alias preferred, sync unscrambled");
      up(L2AS_UP_PACKET, 1'b0, L2AS_KIND_ALIAS, S, "packet uplink");
      migrating = 1'b1;
      up(L2AS_UP_ORIG, 1'b0, L2AS_KIND_ALIAS, S, "migrating visitor alias");
      wr(3'h3, 1'b0, L2AS_KIND_ALIAS, S, 10'h000);
      up(L2AS_UP_ORIG, 1'b0, L2AS_KIND_UNEXCH, H, "migrating unexchanged");
      migrating = 1'b0;
      up(L2AS_UP_REPLY_INDIV, 1'b0, L2AS_KIND_ALIAS, R, "reply echo");
      up(L2AS_UP_REPLY_MGMT, 1'b0, L2AS_KIND_MGMT, M, "mgmt reply");
      up(L2AS_UP_PRESENCE, 1'b0, L2AS_KIND_GROUP, G, "presence group");
      up(L2AS_UP_RESERVED, 1'b0, L2AS_KIND_LABEL, A, "reserved label");
      check(up_hdr.label === L2, "label value");
      up_label_valid = 1'b0;
      up(L2AS_UP_RESERVED, 1'b0, L2AS_KIND_INDIV, A, "reserved without label");
      $display("test uplink done");
      wr(3'h3, 1'b1, L2AS_KIND_ALIAS, S, 10'h000);
      wr(3'h4, 1'b1, L2AS_KIND_UNEXCH, H, 10'h000);
      dn(1'b1, 1'b0, A, 10'h000, 1'b0, 1'b1, 1'b0, L2AS_KIND_INDIV, A, "individual");
      dn(1'b1, 1'b0, S, 10'h000, 1'b0, 1'b1, 1'b0, L2AS_KIND_ALIAS, S, "alias");
      dn(1'b1, 1'b0, G, 10'h000, 1'b0, 1'b1, 1'b0, L2AS_KIND_GROUP, G, "group");
      dn(1'b1, 1'b0, M, 10'h000, 1'b0, 1'b1, 1'b0, L2AS_KIND_MGMT, M, "mgmt");
      dn(1'b1, 1'b0, H, 10'h000, 1'b0, 1'b1, 1'b0, L2AS_KIND_UNEXCH, H, "unexchanged");
      dn(1'b1, 1'b0, 24'hFFFFFF, 10'h000, 1'b1, 1'b1, 1'b1, L2AS_KIND_GROUP, A, "all ones");
      dn(1'b0, 1'b0, 24'h000000, 10'h000, 1'b0, 1'b1, 1'b1, L2AS_KIND_NONE, A, "unaddressed");
      dn(1'b1, 1'b1, 24'h000000, L1, 1'b0, 1'b1, 1'b0, L2AS_KIND_NONE, A, "label");
      dn(1'b1, 1'b1, 24'h000000, 10'h2AA, 1'b0, 1'b0, 1'b0, L2AS_KIND_NONE, A, "foreign label");
      dn(1'b1, 1'b0, 24'h000777, 10'h000, 1'b0, 1'b0, 1'b0, L2AS_KIND_NONE, A, "foreign ssi");
      base.send(1'b1, 1'b0, 1'b1, 24'h000000, 10'h000, 14'h2B3D, 1'b0);
      check(dn_ind.accept === 1'b1 && dn_ind.call_reference === 14'h2B3D && dn_ind.dest_short_id === S,
            "call reference");
      $display("test downlink done");
      @(negedge mclk);
      tab_clear = 1'b1;
      @(negedge mclk);
      tab_clear = 1'b0;
      dn(1'b1, 1'b0, A, 10'h000, 1'b0, 1'b0, 1'b0, L2AS_KIND_NONE, A, "cleared table");
      @(negedge mclk);
      up_req = 1'b1;
      up_purpose = L2AS_UP_REPLY_MGMT;
      @(negedge mclk);
      up_req = 1'b0;
      check(up_hdr.valid === 1'b1 && up_no_identity === 1'b1, "no mgmt identity");
      home_id_valid = 1'b0;
      @(negedge mclk);
      up_req = 1'b1;
      up_purpose = L2AS_UP_ORIG;
      @(negedge mclk);
      up_req = 1'b0;
      check(up_hdr.valid === 1'b1 && up_hdr.kind === L2AS_KIND_NONE && up_no_identity === 1'b1,
            "no identity at all");
      $display("test clear done");
      results();
   end
endmodule
